// ==== febc_defines.vh ====
// Constants for the flash erase and blank check host sequencer.
`ifndef FEBC_DEFINES_VH
`define FEBC_DEFINES_VH
// Flash command addresses and data.
`define FEBC_ADDR_UNLOCK1  26'h0000555
`define FEBC_ADDR_UNLOCK2  26'h00002aa
`define FEBC_DATA_UNLOCK1  16'h00aa
`define FEBC_DATA_UNLOCK2  16'h0055
`define FEBC_DATA_SETUP    16'h0080
`define FEBC_DATA_CHIP     16'h0010
`define FEBC_DATA_SECTOR   16'h0030
`define FEBC_DATA_BLANK    16'h0033
`define FEBC_DATA_SUSPEND  16'h00b0
`define FEBC_DATA_RESUME   16'h0030
`define FEBC_DATA_SRREAD   16'h0070
`define FEBC_DATA_SRCLEAR  16'h0071
`define FEBC_DATA_ERASED   16'hffff
// Status register bit positions.
`define FEBC_SR_READY      7
`define FEBC_SR_ERASEFAIL  5
// Command codes written to the control register.
`define FEBC_OP_NONE       3'h0
`define FEBC_OP_CHIP       3'h1
`define FEBC_OP_SECTOR     3'h2
`define FEBC_OP_BLANK      3'h3
`define FEBC_OP_SUSPEND    3'h4
`define FEBC_OP_RESUME     3'h5
`define FEBC_OP_CLEAR      3'h6
`define FEBC_OP_HWRESET    3'h7
// Wishbone register offsets (word index in adr bits 3:2).
`define FEBC_REG_CTRL      2'h0
`define FEBC_REG_SECTOR    2'h1
`define FEBC_REG_STATUS    2'h2
// Bus strobe and flash reset timing in clock cycles (5 ns each).
`define FEBC_T_WE_LOW      4'h8
`define FEBC_T_WE_HIGH     4'h8
`define FEBC_T_OE_LOW      4'hf
`define FEBC_T_RST_LOW     8'h64
`define FEBC_T_RST_RECOVER 16'h2710
`endif

// ==== febc_sync.v ====
// Two flip-flop synchroniser for one input pin.
`timescale 1ns/1ps
module febc_sync (
   input  wire clk_i,
   input  wire rst_i,
   input  wire d_i,
   output wire q_o
);
   reg meta_ff;
   reg q_ff;

   // First stage feeds only the second stage.
   always @(posedge clk_i) begin
      if (rst_i) begin
         meta_ff <= 1'b1;
         q_ff    <= 1'b1;
      end else begin
         meta_ff <= d_i;
         q_ff    <= meta_ff;
      end
   end

   assign q_o = q_ff;
endmodule

// ==== febc_host.v ====
// Host sequencer that drives flash erase, blank check and suspend commands.
//
// The placing of the registers and the Wishbone register port were chosen for this implementation.
`timescale 1ns/1ps
`include "febc_defines.vh"
module febc_host (
   input  wire        clk_i,
   input  wire        rst_i,
   input  wire [31:0] wb_adr_i,
   input  wire [31:0] wb_dat_i,
   input  wire        wb_we_i,
   input  wire [3:0]  wb_sel_i,
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   output reg  [25:0] flash_addr_o,
   output reg  [15:0] flash_dq_o,
   output reg         flash_dq_oe_o,
   input  wire [15:0] flash_dq_i,
   output reg         flash_ce_n_o,
   output reg         flash_we_n_o,
   output reg         flash_oe_n_o,
   output reg         flash_reset_n_o,
   input  wire        ready_busy_n_i
);
   localparam ST_IDLE  = 4'h0;
   localparam ST_WRITE = 4'h1;
   localparam ST_WHIGH = 4'h2;
   localparam ST_NEXT  = 4'h3;
   localparam ST_WAIT  = 4'h4;
   localparam ST_SRCMD = 4'h5;
   localparam ST_READ  = 4'h6;
   localparam ST_RSTLO = 4'h7;
   localparam ST_RSTRC = 4'h8;

   reg [3:0]  state_ff;
   reg [2:0]  op_ff;
   reg [2:0]  step_ff;
   reg [2:0]  nsteps_ff;
   reg [15:0] cnt_ff;
   reg [25:0] sector_ff;
   reg [15:0] sr_ff;
   reg        busy_ff;
   reg        suspended_ff;
   reg        chip_run_ff;
   reg        overlay_ff;
   reg        refused_ff;
   reg        fail_ff;
   reg        blank_bad_ff;
   reg [2:0]  pend_op_ff;
   reg [15:0] dq_in_ff;
   reg [15:0] dq_meta_ff;
   wire       rb_n;
   reg [25:0] nxt_addr;
   reg [15:0] nxt_data;
   wire       wb_req;
   wire       wr_ctrl;

   febc_sync u_rb (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .d_i   (ready_busy_n_i),
      .q_o   (rb_n)
   );

   // Data pins pass two flip-flops before use.
   always @(posedge clk_i) begin
      dq_meta_ff <= flash_dq_i;
      dq_in_ff   <= dq_meta_ff;
   end

   assign wb_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr_ctrl = wb_req & wb_we_i & wb_sel_i[0] &
                    (wb_adr_i[3:2] == `FEBC_REG_CTRL);

   // Address and data of the current write step of the sequence.
   always @* begin
      nxt_addr = `FEBC_ADDR_UNLOCK1;
      nxt_data = `FEBC_DATA_UNLOCK1;
      case (op_ff)
         `FEBC_OP_CHIP, `FEBC_OP_SECTOR: begin
            case (step_ff)
               3'h0: begin
                  nxt_addr = `FEBC_ADDR_UNLOCK1;
                  nxt_data = `FEBC_DATA_UNLOCK1;
               end
               3'h1, 3'h4: begin
                  nxt_addr = `FEBC_ADDR_UNLOCK2;
                  nxt_data = `FEBC_DATA_UNLOCK2;
               end
               3'h2: begin
                  nxt_addr = `FEBC_ADDR_UNLOCK1;
                  nxt_data = `FEBC_DATA_SETUP;
               end
               3'h3: begin
                  nxt_addr = `FEBC_ADDR_UNLOCK1;
                  nxt_data = `FEBC_DATA_UNLOCK1;
               end
               default: begin
                  if (op_ff == `FEBC_OP_CHIP) begin
                     nxt_addr = `FEBC_ADDR_UNLOCK1;
                     nxt_data = `FEBC_DATA_CHIP;
                  end else begin
                     nxt_addr = sector_ff;
                     nxt_data = `FEBC_DATA_SECTOR;
                  end
               end
            endcase
         end
         `FEBC_OP_BLANK: begin
            nxt_addr = sector_ff | `FEBC_ADDR_UNLOCK1;
            nxt_data = `FEBC_DATA_BLANK;
         end
         `FEBC_OP_SUSPEND: nxt_data = `FEBC_DATA_SUSPEND;
         `FEBC_OP_RESUME:  nxt_data = `FEBC_DATA_RESUME;
         `FEBC_OP_CLEAR:   nxt_data = `FEBC_DATA_SRCLEAR;
         default:          nxt_data = `FEBC_DATA_SRREAD;
      endcase
   end

   // Wishbone slave: one wait state, ack for one cycle.
   always @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o  <= 1'b0;
         wb_dat_o  <= 32'h00000000;
         sector_ff <= 26'h0000000;
      end else begin
         wb_ack_o <= wb_req;
         if (wb_req & wb_we_i & wb_sel_i[0] &
             (wb_adr_i[3:2] == `FEBC_REG_SECTOR))
            sector_ff <= wb_dat_i[25:0];
         if (wb_req & ~wb_we_i) begin
            case (wb_adr_i[3:2])
               `FEBC_REG_SECTOR: wb_dat_o <= {6'h00, sector_ff};
               `FEBC_REG_STATUS: wb_dat_o <= {sr_ff, 7'h00, overlay_ff,
                  refused_ff, fail_ff, blank_bad_ff, chip_run_ff,
                  suspended_ff, ~rb_n, busy_ff, state_ff == ST_IDLE};
               default:          wb_dat_o <= 32'h00000000;
            endcase
         end
      end
   end

   // Sequencer for flash bus cycles and host-side operation tracking.
   always @(posedge clk_i) begin
      if (rst_i) begin
         state_ff        <= ST_IDLE;
         op_ff           <= `FEBC_OP_NONE;
         pend_op_ff      <= `FEBC_OP_NONE;
         step_ff         <= 3'h0;
         nsteps_ff       <= 3'h0;
         cnt_ff          <= 16'h0000;
         sr_ff           <= 16'h0000;
         busy_ff         <= 1'b0;
         suspended_ff    <= 1'b0;
         chip_run_ff     <= 1'b0;
         overlay_ff      <= 1'b0;
         refused_ff      <= 1'b0;
         fail_ff         <= 1'b0;
         blank_bad_ff    <= 1'b0;
         flash_addr_o    <= 26'h0000000;
         flash_dq_o      <= 16'h0000;
         flash_dq_oe_o   <= 1'b0;
         flash_ce_n_o    <= 1'b1;
         flash_we_n_o    <= 1'b1;
         flash_oe_n_o    <= 1'b1;
         flash_reset_n_o <= 1'b1;
      end else begin
         if (wr_ctrl)
            overlay_ff <= wb_dat_i[3];
         case (state_ff)
            ST_IDLE: begin
               if (wr_ctrl & (wb_dat_i[2:0] != `FEBC_OP_NONE)) begin
                  refused_ff <= 1'b0;
                  op_ff      <= wb_dat_i[2:0];
                  step_ff    <= 3'h0;
                  state_ff   <= ST_WRITE;
                  cnt_ff     <= 16'h0000;
                  case (wb_dat_i[2:0])
                     `FEBC_OP_CHIP, `FEBC_OP_SECTOR: begin
                        nsteps_ff <= 3'h5;
                        if (busy_ff | suspended_ff) begin
                           refused_ff <= 1'b1;
                           state_ff   <= ST_IDLE;
                        end
                     end
                     `FEBC_OP_BLANK: begin
                        nsteps_ff <= 3'h0;
                        if (busy_ff | suspended_ff) begin
                           refused_ff <= 1'b1;
                           state_ff   <= ST_IDLE;
                        end
                     end
                     `FEBC_OP_SUSPEND: begin
                        nsteps_ff <= 3'h0;
                        if (~busy_ff | chip_run_ff | suspended_ff |
                            wb_dat_i[3]) begin
                           refused_ff <= 1'b1;
                           state_ff   <= ST_IDLE;
                        end
                     end
                     `FEBC_OP_RESUME: begin
                        nsteps_ff <= 3'h0;
                        if (~suspended_ff | wb_dat_i[3]) begin
                           refused_ff <= 1'b1;
                           state_ff   <= ST_IDLE;
                        end
                     end
                     `FEBC_OP_HWRESET: begin
                        state_ff        <= ST_RSTLO;
                        flash_reset_n_o <= 1'b0;
                     end
                     default: nsteps_ff <= 3'h0;
                  endcase
               end else if (busy_ff & rb_n) begin
                  op_ff    <= `FEBC_OP_NONE;
                  state_ff <= ST_SRCMD;
                  cnt_ff   <= 16'h0000;
               end
            end
            ST_WRITE: begin
               flash_addr_o  <= nxt_addr;
               flash_dq_o    <= nxt_data;
               flash_dq_oe_o <= 1'b1;
               flash_ce_n_o  <= 1'b0;
               flash_we_n_o  <= 1'b0;
               cnt_ff        <= cnt_ff + 16'h0001;
               if (cnt_ff[3:0] == `FEBC_T_WE_LOW) begin
                  flash_we_n_o <= 1'b1;
                  cnt_ff       <= 16'h0000;
                  state_ff     <= ST_WHIGH;
               end
            end
            ST_WHIGH: begin
               cnt_ff <= cnt_ff + 16'h0001;
               if (cnt_ff[3:0] == `FEBC_T_WE_HIGH) begin
                  flash_ce_n_o  <= 1'b1;
                  flash_dq_oe_o <= 1'b0;
                  cnt_ff        <= 16'h0000;
                  state_ff      <= ST_NEXT;
               end
            end
            ST_NEXT: begin
               if (step_ff != nsteps_ff) begin
                  step_ff  <= step_ff + 3'h1;
                  state_ff <= ST_WRITE;
               end else begin
                  state_ff <= ST_IDLE;
                  case (op_ff)
                     `FEBC_OP_CHIP: begin
                        busy_ff     <= 1'b1;
                        chip_run_ff <= 1'b1;
                        state_ff    <= ST_WAIT;
                     end
                     `FEBC_OP_SECTOR, `FEBC_OP_BLANK: begin
                        busy_ff  <= 1'b1;
                        state_ff <= ST_WAIT;
                     end
                     `FEBC_OP_SUSPEND: begin
                        suspended_ff <= 1'b1;
                        busy_ff      <= 1'b0;
                        state_ff     <= ST_WAIT;
                     end
                     `FEBC_OP_RESUME: begin
                        suspended_ff <= 1'b0;
                        busy_ff      <= 1'b1;
                        state_ff     <= ST_WAIT;
                     end
                     default: op_ff <= `FEBC_OP_NONE;
                  endcase
               end
            end
            ST_WAIT: begin
               // Give the flash time to drop or raise its busy pin.
               cnt_ff <= cnt_ff + 16'h0001;
               if (cnt_ff[3:0] == `FEBC_T_OE_LOW) begin
                  cnt_ff   <= 16'h0000;
                  state_ff <= ST_IDLE;
                  if (op_ff == `FEBC_OP_SUSPEND)
                     state_ff <= ST_SRCMD;
               end
            end
            ST_SRCMD: begin
               // Status read command, then one read of the status word.
               flash_addr_o  <= `FEBC_ADDR_UNLOCK1;
               flash_dq_o    <= `FEBC_DATA_SRREAD;
               flash_dq_oe_o <= 1'b1;
               flash_ce_n_o  <= 1'b0;
               flash_we_n_o  <= 1'b0;
               cnt_ff        <= cnt_ff + 16'h0001;
               if (cnt_ff[3:0] == `FEBC_T_WE_LOW) begin
                  flash_we_n_o  <= 1'b1;
                  flash_dq_oe_o <= 1'b0;
                  cnt_ff        <= 16'h0000;
                  state_ff      <= ST_READ;
               end
            end
            ST_READ: begin
               flash_oe_n_o <= 1'b0;
               cnt_ff       <= cnt_ff + 16'h0001;
               if (cnt_ff[3:0] == `FEBC_T_OE_LOW) begin
                  flash_oe_n_o <= 1'b1;
                  flash_ce_n_o <= 1'b1;
                  sr_ff        <= dq_in_ff;
                  cnt_ff       <= 16'h0000;
                  state_ff     <= ST_IDLE;
                  if (dq_in_ff[`FEBC_SR_READY]) begin
                     busy_ff      <= 1'b0;
                     chip_run_ff  <= 1'b0;
                     fail_ff      <= dq_in_ff[`FEBC_SR_ERASEFAIL];
                     blank_bad_ff <= dq_in_ff[`FEBC_SR_ERASEFAIL];
                  end
               end
            end
            ST_RSTLO: begin
               cnt_ff <= cnt_ff + 16'h0001;
               if (cnt_ff[7:0] == `FEBC_T_RST_LOW) begin
                  flash_reset_n_o <= 1'b1;
                  cnt_ff          <= 16'h0000;
                  state_ff        <= ST_RSTRC;
               end
            end
            ST_RSTRC: begin
               cnt_ff <= cnt_ff + 16'h0001;
               if (cnt_ff == `FEBC_T_RST_RECOVER) begin
                  busy_ff      <= 1'b0;
                  suspended_ff <= 1'b0;
                  chip_run_ff  <= 1'b0;
                  fail_ff      <= 1'b1;
                  op_ff        <= `FEBC_OP_NONE;
                  state_ff     <= ST_IDLE;
               end
            end
            default: state_ff <= ST_IDLE;
         endcase
      end
   end
endmodule

// ==== febc_host_monitor.sv ====
// Concurrent checks on the host sequencer's bus and flash pins.
`timescale 1ns/1ps
module febc_host_monitor (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_ack_o,
   input wire logic [25:0] flash_addr_o,
   input wire logic [15:0] flash_dq_o,
   input wire logic        flash_dq_oe_o,
   input wire logic        flash_ce_n_o,
   input wire logic        flash_we_n_o,
   input wire logic        flash_oe_n_o,
   input wire logic        flash_reset_n_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic [7:0] rst_low_ff;
   // Counts how long the flash reset pin has been held low.
   always @(posedge clk_i) begin
      if (rst_i || flash_reset_n_o) rst_low_ff <= 8'h00;
      else if (rst_low_ff != 8'hff) rst_low_ff <= rst_low_ff + 8'h01;
   end
   // One command write strobe: eight cycles low, then released.
   sequence we_low_eight;
      !flash_we_n_o [*8] ##1 flash_we_n_o;
   endsequence
   // Address and data held with the chip still selected after the strobe.
   sequence write_hold;
      (!flash_ce_n_o && $stable(flash_addr_o) && $stable(flash_dq_o)) [*8];
   endsequence
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=>
      wb_ack_o) else $error("ack missing one cycle after request");
   a_ack_quiet: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
      else $error("ack without request");
   a_rst_quiet: assert property (disable iff (1'b0) rst_i |=> (!wb_ack_o &&
      flash_we_n_o && flash_ce_n_o && flash_oe_n_o && flash_reset_n_o &&
      !flash_dq_oe_o)) else $error("outputs not quiet in reset");
   a_we_pulse: assert property ($fell(flash_we_n_o) |-> we_low_eight)
      else $error("write strobe width wrong");
   a_write_hold: assert property ($rose(flash_we_n_o) |-> write_hold)
      else $error("address or data changed after write strobe");
   a_write_stable: assert property (!flash_we_n_o &&
      $past(!flash_we_n_o) |-> $stable(flash_addr_o) && $stable(flash_dq_o))
      else $error("address or data moved during write strobe");
   a_we_in_ce: assert property (!flash_we_n_o |-> !flash_ce_n_o &&
      flash_dq_oe_o && flash_oe_n_o) else $error("write strobe not framed");
   a_read_no_drive: assert property (!flash_oe_n_o |-> !flash_dq_oe_o &&
      flash_we_n_o) else $error("data driven during a read");
   a_oe_width: assert property ($fell(flash_oe_n_o) |-> !flash_oe_n_o [*8])
      else $error("read strobe too short");
   a_reset_width: assert property ($rose(flash_reset_n_o) |->
      rst_low_ff >= 8'd100)
      else $error("flash reset pulse too short");
   a_reset_no_write: assert property (!flash_reset_n_o |-> flash_we_n_o)
      else $error("write strobe during flash reset");
endmodule

// ==== febc_flash_model.sv ====
// Behavioural flash device: erase, blank check, suspend and status read.
`timescale 1ns/1ps
module febc_flash_model #(
   parameter int ERASE_CYC = 1500,
   parameter int BLANK_CYC = 300
) (
   input  wire logic        clk_i,
   input  wire logic [25:0] addr_i,
   input  wire logic [15:0] dq_i,
   input  wire logic        ce_n_i,
   input  wire logic        we_n_i,
   input  wire logic        oe_n_i,
   input  wire logic        reset_n_i,
   input  wire logic        not_blank_i,
   output logic      [15:0] dq_o,
   output logic             ready_busy_n_o
);
   localparam logic [10:0] SA [5] = '{11'h555, 11'h2aa, 11'h555, 11'h555, 11'h2aa};
   localparam logic [7:0]  SD [5] = '{8'haa, 8'h55, 8'h80, 8'haa, 8'h55};
   logic [2:0]  stage = 3'h0;
   logic        busy = 0, susp = 0, chip = 0, fail = 0, srm = 0, nb = 0;
   logic [15:0] last = 16'h0000;
   int          left = 0;
   wire  [15:0] sr = {8'h00, ~busy | susp, susp, fail, 5'h00};
   // Released lines show the inverse of the last value read.
   assign dq_o = (ce_n_i || oe_n_i) ? ~last : srm ? sr
                 : busy ? ~last : 16'hffff;
   assign ready_busy_n_o = !(busy && !susp);
   // Commands are taken at the rising write strobe.
   always @(posedge we_n_i) begin
      if (!ce_n_i && reset_n_i) begin
         if (dq_i == 16'h0070) srm <= 1;
         else if (busy && !susp) begin
            if (dq_i == 16'h00b0 && !chip) susp <= 1;
         end else if (susp) begin
            if (dq_i == 16'h0030) susp <= 0;
            else if (dq_i == 16'h0071) fail <= 0;
         end else if (stage == 3'h5 && (dq_i == 16'h0010 || dq_i == 16'h0030)) begin
            busy <= 1;
            chip <= (dq_i == 16'h0010);
            left <= ERASE_CYC;
            fail <= 0;
            stage <= 3'h0;
         end else if (stage == 3'h0 && dq_i == 16'h0033 && addr_i[10:0] == 11'h555) begin
            busy <= 1;
            nb <= not_blank_i;
            left <= not_blank_i ? BLANK_CYC / 4 : BLANK_CYC;
         end else if (stage < 3'h5 && addr_i[10:0] == SA[stage] && dq_i[7:0] == SD[stage])
            stage <= stage + 3'h1;
         else stage <= 3'h0;
      end
   end
   // Leaves status mode once the status word has been read.
   always @(posedge oe_n_i) srm <= 0;
   // Runs the embedded algorithm and honours the hardware reset.
   always @(posedge clk_i) begin
      if (!ce_n_i && !oe_n_i) last <= dq_o;
      if (!reset_n_i) begin
         busy <= 0;
         susp <= 0;
         chip <= 0;
         stage <= 3'h0;
      end else if (busy && !susp) begin
         if (left > 0) left <= left - 1;
         else begin
            busy <= 0;
            chip <= 0;
            fail <= nb;
            nb <= 0;
         end
      end
   end
endmodule

// ==== febc_host_test.sv ====
// Testbench for the flash erase and blank check host sequencer.
`timescale 1ns/1ps
`include "febc_defines.vh"
module febc_host_test;
   logic        clk_i = 0;
   logic        rst_i = 1;
   logic [31:0] wb_adr_i = 0;
   logic [31:0] wb_dat_i = 0;
   logic        wb_we_i = 0;
   logic [3:0]  wb_sel_i = 4'hf;
   logic        wb_cyc_i = 0;
   logic        wb_stb_i = 0;
   logic        not_blank = 0;
   wire  [31:0] wb_dat_o;
   wire         wb_ack_o;
   wire  [25:0] flash_addr_o;
   wire  [15:0] flash_dq_o, flash_dq_i;
   wire         flash_dq_oe_o, flash_ce_n_o, flash_we_n_o, flash_oe_n_o;
   wire         flash_reset_n_o, ready_busy_n;
   int          n_errors = 0;
   int          total_checks = 0;
   int          n;
   logic [25:0] log_a[$];
   logic [15:0] log_d[$];
   logic [31:0] rd;
   febc_host u_febc_host (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
      .wb_dat_i(wb_dat_i), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .flash_addr_o(flash_addr_o), .flash_dq_o(flash_dq_o),
      .flash_dq_oe_o(flash_dq_oe_o), .flash_dq_i(flash_dq_i),
      .flash_ce_n_o(flash_ce_n_o), .flash_we_n_o(flash_we_n_o),
      .flash_oe_n_o(flash_oe_n_o), .flash_reset_n_o(flash_reset_n_o),
      .ready_busy_n_i(ready_busy_n));
   febc_flash_model u_febc_flash_model (.clk_i(clk_i), .addr_i(flash_addr_o),
      .dq_i(flash_dq_o), .ce_n_i(flash_ce_n_o), .we_n_i(flash_we_n_o),
      .oe_n_i(flash_oe_n_o), .reset_n_i(flash_reset_n_o),
      .not_blank_i(not_blank), .dq_o(flash_dq_i), .ready_busy_n_o(ready_busy_n));
   // Makes the 200 MHz clock.
   initial begin
      forever #2.5 clk_i = ~clk_i;
   end
   // Logs every command write seen on the flash pins.
   always @(posedge flash_we_n_o) begin
      if (flash_ce_n_o === 1'b0) begin
         log_a.push_back(flash_addr_o);
         log_d.push_back(flash_dq_o);
      end
   end
   task automatic close_out();
      $display("Checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] got, exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One classic bus cycle; waits for ack, then releases for a cycle.
   task automatic wb(input logic we, input logic [31:0] adr, dat);
      int k;
      k = 0;
      wb_cyc_i <= 1;
      wb_stb_i <= 1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= dat;
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1) begin
         k++;
         if (k > 50) begin
            n_errors++;
            close_out();
         end
         @(posedge clk_i);
      end
      rd = wb_dat_o;
      wb_cyc_i <= 0;
      wb_stb_i <= 0;
      wb_we_i <= 0;
      @(posedge clk_i);
   endtask
   task automatic op(input logic [2:0] code);
      log_a.delete();
      log_d.delete();
      wb(1, 32'h0, {29'h0, code});
   endtask
   // Polls the status register until the masked bits match.
   task automatic wait_st(input logic [31:0] mask, val);
      for (n = 0; n < 8000; n++) begin
         wb(0, 32'h8, 32'h0);
         if ((rd & mask) === val) return;
      end
      n_errors++;
      close_out();
   endtask
   task automatic wait_log(input int cnt);
      for (n = 0; n < 4000 && log_a.size() < cnt; n++) @(posedge clk_i);
      if (log_a.size() < cnt) begin
         n_errors++;
         close_out();
      end
   endtask
   // Compares the six-write erase sequence with its expected form.
   task automatic chk_seq(input logic [25:0] a6, input logic [15:0] d6);
      logic [25:0] ea[6] = '{26'h555, 26'h2aa, 26'h555, 26'h555, 26'h2aa, a6};
      logic [15:0] ed[6] = '{16'haa, 16'h55, 16'h80, 16'haa, 16'h55, d6};
      chk("write count", 32'(log_a.size()), 32'd6);
      for (int i = 0; i < 6 && i < log_a.size(); i++) begin
         chk("flash addr", {6'h0, log_a[i]}, {6'h0, ea[i]});
         chk("flash data", {16'h0, log_d[i]}, {16'h0, ed[i]});
      end
   endtask
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 0;
      @(posedge clk_i);
      wb(0, 32'h8, 32'h0);
      chk("status after reset", rd & 32'h3ff, 32'h1);
      wb(0, 32'hc, 32'h0);
      chk("unmapped read", rd, 32'h0);
      wb(0, 32'h0, 32'h0);
      chk("control read", rd, 32'h0);
      $display("Test reset and map done");
      op(`FEBC_OP_CHIP);
      wait_log(6);
      chk_seq(26'h555, 16'h10);
      chk("busy pin", {31'h0, ready_busy_n}, 32'h0);
      wait_st(32'h1, 32'h1);
      op(`FEBC_OP_SUSPEND);
      wait_st(32'h0, 32'h0);
      chk("suspend refused", rd & 32'h88, 32'h80);
      chk("no suspend write", 32'(log_a.size()), 32'd0);
      wait_st(32'h3, 32'h1);
      chk("not suspended", rd & 32'h8, 32'h0);
      chk("ready in status word", rd & 32'h00a00000, 32'h00800000);
      $display("Test chip erase done");
      wb(1, 32'h4, 32'h00020000);
      op(`FEBC_OP_SECTOR);
      wait_log(6);
      chk_seq(26'h20000, 16'h30);
      wait_st(32'h1, 32'h1);
      op(`FEBC_OP_SUSPEND);
      wait_st(32'h9, 32'h9);
      chk("suspend code", {16'h0, log_d[0]}, 32'h00b0);
      chk("pin ready", {31'h0, ready_busy_n}, 32'h1);
      op(`FEBC_OP_BLANK);
      wait_st(32'h0, 32'h0);
      chk("blank refused", {31'h0, rd[7] | rd[9]}, 32'h1);
      chk("no blank write", 32'(log_a.size()), 32'd0);
      wb(1, 32'h0, 32'h0000000d);
      wait_st(32'h0, 32'h0);
      chk("overlay resume", rd & 32'h188, 32'h188);
      op(`FEBC_OP_CLEAR);
      wait_log(1);
      chk("clear code", {16'h0, log_d[0]}, 32'h0071);
      wait_st(32'h9, 32'h9);
      op(`FEBC_OP_RESUME);
      wait_log(1);
      chk("resume code", {16'h0, log_d[0]}, 32'h0030);
      wait_st(32'h3, 32'h1);
      chk("erase done", rd & 32'h48, 32'h0);
      $display("Test sector erase done");
      for (int b = 0; b < 2; b++) begin
         not_blank <= b[0];
         op(`FEBC_OP_BLANK);
         wait_log(1);
         chk("blank addr", {6'h0, log_a[0]}, 32'h00020555);
         chk("blank data", {16'h0, log_d[0]}, 32'h0033);
         wait_st(32'h3, 32'h1);
         chk("blank result", {31'h0, rd[5]}, {31'h0, b[0]});
      end
      $display("Test blank check done");
      op(`FEBC_OP_CHIP);
      wait_log(6);
      wait_st(32'h1, 32'h1);
      op(`FEBC_OP_HWRESET);
      wait_st(32'h1, 32'h1);
      chk("abort flagged", {31'h0, rd[6]}, 32'h1);
      chk("reset released", {31'h0, flash_reset_n_o}, 32'h1);
      op(`FEBC_OP_CHIP);
      wait_log(6);
      chk_seq(26'h555, 16'h10);
      wait_st(32'h3, 32'h1);
      chk("abort cleared", {31'h0, rd[6]}, 32'h0);
      $display("Test hardware reset done");
      close_out();
   end
endmodule
bind febc_host febc_host_monitor u_febc_host_monitor (.clk_i(clk_i),
   .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_ack_o(wb_ack_o), .flash_addr_o(flash_addr_o), .flash_dq_o(flash_dq_o),
   .flash_dq_oe_o(flash_dq_oe_o), .flash_ce_n_o(flash_ce_n_o),
   .flash_we_n_o(flash_we_n_o), .flash_oe_n_o(flash_oe_n_o),
   .flash_reset_n_o(flash_reset_n_o));
